// ==== logic/flash_spm_pkg.sv ====
// Constants and carrier types for the flash self-programming control block.
// Assumes a core-side register port at I/O offset 0x37 and a flash macro with busy handshake.
package flash_spm_pkg;

    localparam logic [5:0] SPC_ADDR          = 6'h37;
    localparam logic [7:0] SPC_RESET         = 8'h00;
    localparam int         BIT_APP_BUSY      = 6;
    localparam int         BIT_APP_READ      = 4;
    localparam int         BIT_LOCK_SET      = 3;
    localparam int         BIT_PAGE_WRITE    = 2;
    localparam int         BIT_PAGE_ERASE    = 1;
    localparam int         BIT_STORE_ENABLE  = 0;
    localparam logic [4:0] CMD_FILL          = 5'h01;
    localparam logic [4:0] CMD_ERASE         = 5'h03;
    localparam logic [4:0] CMD_WRITE         = 5'h05;
    localparam logic [4:0] CMD_LOCK          = 5'h09;
    localparam logic [4:0] CMD_APP_READ      = 5'h11;
    localparam int         STORE_WINDOW_CYC  = 4;
    localparam int         LOAD_WINDOW_CYC   = 5;
    localparam int         PAGE_MSB          = 14;
    localparam int         PAGE_LSB          = 7;
    localparam int         WORD_MSB          = 6;
    localparam int         WORD_LSB          = 1;
    localparam int         LOCK_MSB          = 5;
    localparam int         LOCK_LSB          = 2;
    localparam logic [15:0] SEL_FUSE_LOW     = 16'h0000;
    localparam logic [15:0] SEL_LOCK         = 16'h0001;
    localparam logic [15:0] SEL_FUSE_HIGH    = 16'h0003;

    typedef enum logic [1:0] {
        OP_IDLE  = 2'b00,
        OP_ARMED = 2'b01,
        OP_BUSY  = 2'b11
    } op_state_e;

    // Core-side register access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } io_req_s;

    // Store or load from the core
    typedef struct packed {
        logic        store;
        logic        load;
        logic [15:0] z;
        logic [15:0] r1r0;
    } spm_req_s;

    // Request to the flash array
    typedef struct packed {
        logic        erase;
        logic        write;
        logic        lock;
        logic [7:0]  page;
        logic [3:0]  lock_data;
    } flash_cmd_s;

endpackage

// ==== logic/spm_page_buffer.sv ====
// Temporary page buffer in flip-flops, one word per slot.
// Assumes writes and reads on one clock; cleared by the owner after a page write.
`timescale 1ns/1ps
`default_nettype none
module spm_page_buffer #(
    parameter int WORDS = 64,
    parameter int AW    = 6
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          sys_rst,
    // Fill side
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_idx,
    input  wire logic [15:0]   wr_data,
    input  wire logic          clear,
    // Drain side
    input  wire logic [AW-1:0] rd_idx,
    output logic      [15:0]   rd_data
);
    logic [15:0] mem [WORDS];

    // Refuse a depth that the index cannot address exactly
    if (WORDS != (1 << AW)) begin : g_bad_size
        $error("spm_page_buffer: WORDS must equal 2**AW");
    end

    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < WORDS; i++) begin
            if (sys_rst || clear) begin
                mem[i] <= 16'hFFFF;
            end else if (wr_en && wr_idx == AW'(i)) begin
                mem[i] <= wr_data;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        rd_data <= mem[rd_idx];
    end
endmodule
`default_nettype wire

// ==== logic/flash_self_program_control.sv ====
// Self-programming control: control register, timed arming, command decode, page buffer and core stall.
// Assumes the core presents store/load requests as one-cycle pulses and the flash reports busy while working.
// Functional notes
// R1: EEPROM write blocks all flash programming; code only refuses arming, an armed store still launches
// R2: EEPROM write blocks fuse and lock reads
// R3: Software checks EEPROM busy before control write
// R4: Page from Z14:Z7, word from Z6:Z1
// R5: Software zeroes word select for page write
// R6: Z0 zero for stores; load byte select
// R7: Lock set ignores pointer entirely
// R8: Software uses same page for erase/write
// R9: Bits 7 and 5 read zero
// R10: Application busy bit always reads zero
// R11: Software re-enables application read timely
// R12: Lock set: store programs, load reads
// R13: Lock set clears on completion or timeout
// R14: Page write copies buffer to page
// R15: Page write bit clears on done/timeout
// R16: Page erase erases addressed page
// R17: Page erase bit clears on done/timeout
// R18: Core stalled during erase and write
// R19: Store enable alone fills buffer word
// R20: Store enable timeout; busy during operation
// R21: Only listed command codes take effect
// R22: Reset does not abort flash write
// R23: Lock data from R0 bits 5..2
// R24: Pointer selects lock, fuse low, high
// R25: Control writes ignored while operation runs
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_control
    import flash_spm_pkg::*;
#(
    parameter int BUF_WORDS = 64,
    parameter int BUF_AW    = 6
) (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       sys_rst,
    // Control register port
    input  wire flash_spm_pkg::io_req_s     io_req,
    output logic                [7:0]       io_rdata,
    // Store and load requests
    input  wire flash_spm_pkg::spm_req_s    spm_req,
    output logic                            load_valid,
    output logic                [7:0]       load_data,
    output logic                            core_stall,
    // EEPROM status
    input  wire logic                       eeprom_write_busy,
    // Lock and fuse values, zero means programmed
    input  wire logic           [7:0]       lock_bits,
    input  wire logic           [7:0]       fuse_low,
    input  wire logic           [7:0]       fuse_high,
    // Flash array
    output flash_spm_pkg::flash_cmd_s       flash_cmd,
    output logic                            flash_start,
    output logic                [BUF_AW-1:0] flash_word_idx,
    output logic                [15:0]      flash_word_data,
    input  wire logic                       flash_busy,
    output logic                            app_read_enable
);
    import flash_spm_pkg::*;

    localparam logic [2:0] STORE_LAST = 3'(STORE_WINDOW_CYC - 1);
    localparam logic [2:0] LOAD_LAST  = 3'(LOAD_WINDOW_CYC - 1);

    // Refuse sizes that the pointer fields and the age counter cannot serve
    if (BUF_AW != WORD_MSB - WORD_LSB + 1) begin : g_bad_aw
        $error("flash_self_program_control: BUF_AW must match pointer word field");
    end

    if (BUF_WORDS != (1 << BUF_AW)) begin : g_bad_words
        $error("flash_self_program_control: BUF_WORDS must equal 2**BUF_AW");
    end

    if (LOAD_WINDOW_CYC > 8 || STORE_WINDOW_CYC > LOAD_WINDOW_CYC) begin : g_bad_window
        $error("flash_self_program_control: arming windows do not fit the age counter");
    end

    op_state_e   state;
    logic [4:0]  ctrl;
    logic [2:0]  age;
    logic        rst_seen;
    logic        busy_seen;
    logic        buf_clear;
    logic        buf_wr;
    logic [15:0] buf_rdata;
    logic [BUF_AW-1:0] rd_idx;
    logic [BUF_AW-1:0] idx_q;
    logic        buf_rst;

    // EEPROM busy comes from the same clock domain; no synchroniser
    logic ee_block;
    assign ee_block = eeprom_write_busy;

    logic store_ok;
    logic load_ok;
    logic is_cmd;
    assign store_ok = (state == OP_ARMED) && spm_req.store && (age <= STORE_LAST);
    // R12: lock-set load window
    assign load_ok  = (state == OP_ARMED) && spm_req.load && (ctrl == CMD_LOCK) && (age <= LOAD_LAST);
    assign is_cmd   = (io_req.wdata[4:0] == CMD_FILL) || (io_req.wdata[4:0] == CMD_ERASE) ||
                      (io_req.wdata[4:0] == CMD_WRITE) || (io_req.wdata[4:0] == CMD_LOCK) ||
                      (io_req.wdata[4:0] == CMD_APP_READ);

    // Control register, arming window and operation state
    always_ff @(posedge clk_sys) begin
        if (sys_rst && state != OP_BUSY) begin
            state <= OP_IDLE;
            ctrl  <= SPC_RESET[4:0];
            age   <= 3'h0;
        end else begin
            case (state)
                OP_IDLE: begin
                    // R21: accepted codes only
                    // R1: EEPROM blocks arming
                    if (io_req.wr && io_req.addr == SPC_ADDR && is_cmd && !ee_block) begin
                        state <= OP_ARMED;
                        ctrl  <= io_req.wdata[4:0];
                        age   <= 3'h0;
                    end
                end
                OP_ARMED: begin
                    age <= age + 3'h1;
                    // R16: erase launch
                    // R14: write launch
                    if (store_ok && (ctrl == CMD_ERASE || ctrl == CMD_WRITE)) begin
                        state <= OP_BUSY;
                    // R13: clear after store or load
                    // R19: fill completes in one cycle
                    end else if (store_ok || load_ok) begin
                        state <= OP_IDLE;
                        ctrl  <= 5'h00;
                    // R13: load window for lock set
                    end else if (ctrl == CMD_LOCK ? age >= LOAD_LAST : age >= STORE_LAST) begin
                        // R15: timeout clears command
                        // R17: timeout clears command
                        // R20: store enable timeout
                        state <= OP_IDLE;
                        ctrl  <= 5'h00;
                    end
                end
                OP_BUSY: begin
                    // R25: control writes ignored here
                    // R22: finish even under reset
                    if (busy_seen && !flash_busy) begin
                        state <= OP_IDLE;
                        ctrl  <= 5'h00;
                    end
                end
                default: begin
                    state <= OP_IDLE;
                    ctrl  <= 5'h00;
                end
            endcase
        end
    end

    // Flash busy acknowledged once the operation has started
    always_ff @(posedge clk_sys) begin
        if (state != OP_BUSY) begin
            busy_seen <= 1'b0;
        end else if (flash_busy) begin
            busy_seen <= 1'b1;
        end
    end

    // Reset is registered one cycle for the register view
    always_ff @(posedge clk_sys) begin
        rst_seen <= sys_rst;
    end

    // Launch of erase, write and lock programming
    always_ff @(posedge clk_sys) begin
        if (sys_rst && state != OP_BUSY) begin
            flash_start <= 1'b0;
            flash_cmd   <= '0;
        end else begin
            flash_start <= 1'b0;
            if (store_ok && ctrl != CMD_FILL && ctrl != CMD_APP_READ) begin
                flash_start         <= 1'b1;
                flash_cmd.erase     <= (ctrl == CMD_ERASE);
                flash_cmd.write     <= (ctrl == CMD_WRITE);
                flash_cmd.lock      <= (ctrl == CMD_LOCK);
                // R4: page from pointer, Z15 ignored
                // R7: lock set leaves page alone
                if (ctrl != CMD_LOCK) begin
                    flash_cmd.page <= spm_req.z[PAGE_MSB:PAGE_LSB];
                end
                // R23: lock data from R0
                flash_cmd.lock_data <= spm_req.r1r0[LOCK_MSB:LOCK_LSB];
            end
        end
    end

    // R18: stall during erase and write
    always_ff @(posedge clk_sys) begin
        if (sys_rst && state != OP_BUSY) begin
            core_stall <= 1'b0;
        end else begin
            core_stall <= (state == OP_BUSY && !(busy_seen && !flash_busy)) ||
                          (store_ok && (ctrl == CMD_ERASE || ctrl == CMD_WRITE));
        end
    end

    // R11: application read re-enable
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            app_read_enable <= 1'b1;
        end else if (store_ok && ctrl == CMD_ERASE) begin
            app_read_enable <= 1'b0;
        end else if (store_ok && ctrl == CMD_APP_READ) begin
            app_read_enable <= 1'b1;
        end
    end

    // R19: fill word, pointer LSB ignored
    // R6: Z0 not used for stores
    assign buf_wr    = store_ok && ctrl == CMD_FILL;
    assign buf_clear = (state == OP_BUSY) && flash_cmd.write && busy_seen && !flash_busy;
    // R22: buffer keeps its words through reset during an operation
    assign buf_rst   = sys_rst && state != OP_BUSY;

    // Word stream to the flash array during page write
    always_ff @(posedge clk_sys) begin
        if (sys_rst && state != OP_BUSY) begin
            rd_idx <= '0;
        end else if (state != OP_BUSY) begin
            // R5: page write assumes word select zero
            rd_idx <= '0;
        end else if (flash_busy && flash_cmd.write) begin
            rd_idx <= rd_idx + BUF_AW'(1);
        end
    end

    spm_page_buffer #(
        .WORDS (BUF_WORDS),
        .AW    (BUF_AW)
    ) u_buffer (
        .clk_sys (clk_sys),
        .sys_rst (buf_rst),
        .wr_en   (buf_wr),
        .wr_idx  (spm_req.z[WORD_MSB:WORD_LSB]),
        .wr_data (spm_req.r1r0),
        .clear   (buf_clear),
        .rd_idx  (rd_idx),
        .rd_data (buf_rdata)
    );

    // R22: stream keeps running through reset
    always_ff @(posedge clk_sys) begin
        if (sys_rst && state != OP_BUSY) begin
            idx_q           <= '0;
            flash_word_idx  <= '0;
            flash_word_data <= 16'hFFFF;
        end else begin
            // R14: index delayed twice to pair with the registered read
            idx_q           <= rd_idx;
            flash_word_idx  <= idx_q;
            flash_word_data <= buf_rdata;
        end
    end

    // R24: lock and fuse read select
    // R2: EEPROM write blocks these reads
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            load_valid <= 1'b0;
            load_data  <= 8'h00;
        end else begin
            load_valid <= 1'b0;
            if (load_ok && !ee_block) begin
                load_valid <= 1'b1;
                if (spm_req.z == SEL_LOCK) begin
                    load_data <= lock_bits;
                end else if (spm_req.z == SEL_FUSE_HIGH) begin
                    load_data <= fuse_high;
                end else if (spm_req.z == SEL_FUSE_LOW) begin
                    load_data <= fuse_low;
                end else begin
                    // Unknown select reads back all ones
                    load_data <= 8'hFF;
                end
            end
        end
    end

    // R9: reserved bits read zero
    // R10: busy bit reads zero
    // R20: store enable high while busy
    always_ff @(posedge clk_sys) begin
        if (sys_rst && !rst_seen && state != OP_BUSY) begin
            io_rdata <= SPC_RESET;
        end else if (io_req.rd && io_req.addr == SPC_ADDR) begin
            // Armed or busy command shows in the low bits
            io_rdata <= {3'b000, (state == OP_IDLE) ? 5'h00 : ctrl};
        end else begin
            io_rdata <= 8'h00;
        end
    end

endmodule
`default_nettype wire

// ==== test/flash_spm_asserts.sv ====
// Concurrent checks on the self-programming control ports.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module flash_spm_asserts (
    // Clock and reset
    input wire logic                    clk_sys,
    input wire logic                    sys_rst,
    // Core side
    input wire flash_spm_pkg::io_req_s  io_req,
    input wire logic [7:0]              io_rdata,
    input wire flash_spm_pkg::spm_req_s spm_req,
    input wire logic                    load_valid,
    input wire logic                    core_stall,
    input wire logic                    eeprom_write_busy,
    // Flash side
    input wire flash_spm_pkg::flash_cmd_s flash_cmd,
    input wire logic                    flash_start,
    input wire logic                    flash_busy
);
    import flash_spm_pkg::*;
    logic [15:0] z_q;
    logic [15:0] d_q;
    always_ff @(posedge clk_sys) begin
        z_q <= spm_req.z;
        d_q <= spm_req.r1r0;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    chk_rsvd_read_zero: assert property (io_rdata[7:5] == 3'h0)
        else $error("reserved control bits read nonzero");
    chk_start_has_store: assert property (flash_start |-> $past(spm_req.store))
        else $error("flash start without store");
    chk_stall_on_launch: assert property (flash_start && (flash_cmd.erase || flash_cmd.write) |-> core_stall)
        else $error("no stall at launch");
    chk_stall_holds: assert property (core_stall && flash_busy |=> core_stall)
        else $error("stall dropped while flash busy");
    chk_page_from_ptr: assert property (flash_start && !flash_cmd.lock |-> flash_cmd.page == z_q[14:7])
        else $error("page not from pointer");
    chk_lock_data_src: assert property (flash_start && flash_cmd.lock |-> flash_cmd.lock_data == d_q[5:2])
        else $error("lock data not from low byte");
    chk_eeprom_blocks: assert property (eeprom_write_busy [*6] |=> !flash_start)
        else $error("flash op during eeprom write");
    chk_load_cause: assert property (load_valid |-> $past(spm_req.load) && !$past(eeprom_write_busy))
        else $error("load answer without allowed load");
    chk_window_expiry: assert property ((!io_req.wr) [*4] ##1 spm_req.store |=> !flash_start)
        else $error("store taken after window");
endmodule
bind flash_self_program_control flash_spm_asserts u_chk (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .io_req(io_req), .io_rdata(io_rdata),
    .spm_req(spm_req), .load_valid(load_valid), .core_stall(core_stall),
    .eeprom_write_busy(eeprom_write_busy), .flash_cmd(flash_cmd),
    .flash_start(flash_start), .flash_busy(flash_busy)
);
`default_nettype wire

// ==== test/flash_array_model.sv ====
// Behavioural flash array: busy for a set count after each start pulse.
// Assumes start is one cycle wide; ignores system reset so work finishes.
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
    // Clock
    input wire logic        clk_sys,
    // Command side
    input wire logic        flash_start,
    input wire logic [15:0] busy_cycles,
    output logic            flash_busy
);
    logic [15:0] left = 16'h0;
    always @(posedge clk_sys) begin
        if (flash_start) begin
            left <= busy_cycles;
        end else if (left != 16'h0) begin
            left <= left - 16'h1;
        end
    end
    assign flash_busy = (left != 16'h0);
endmodule
`default_nettype wire

// ==== test/tb_flash_self_program_control.sv ====
// Self-checking bench for the self-programming control block.
// Assumes the flash array model on the flash port; bench acts as the core.
`timescale 1ns/1ps
`default_nettype none
module tb_flash_self_program_control;
    import flash_spm_pkg::*;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    io_req_s     io_req = '0;
    spm_req_s    spm_req = '0;
    logic        eeprom_write_busy = 1'b0;
    logic [7:0]  lock_bits = 8'h0, fuse_low = 8'h0, fuse_high = 8'h0;
    logic [15:0] busy_cycles = 16'h50;
    logic [7:0]  io_rdata, load_data, v;
    logic        load_valid, core_stall, flash_start, flash_busy, app_read_enable;
    flash_cmd_s  flash_cmd;
    logic [5:0]  flash_word_idx;
    logic [15:0] flash_word_data, z, d;
    logic [15:0] exp_buf [64];
    logic [15:0] seen [64];
    logic        in_wr = 1'b0, busy_d = 1'b0;
    logic [4:0]  c;
    logic [4:0]  codes [4] = '{CMD_FILL, CMD_ERASE, CMD_WRITE, CMD_LOCK};
    logic [15:0] sels [3] = '{SEL_LOCK, SEL_FUSE_LOW, SEL_FUSE_HIGH};
    int          n_errors = 0, checks = 0;

    flash_self_program_control dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .io_req(io_req),
        .io_rdata(io_rdata), .spm_req(spm_req), .load_valid(load_valid), .load_data(load_data),
        .core_stall(core_stall), .eeprom_write_busy(eeprom_write_busy), .lock_bits(lock_bits),
        .fuse_low(fuse_low), .fuse_high(fuse_high), .flash_cmd(flash_cmd), .flash_start(flash_start),
        .flash_word_idx(flash_word_idx), .flash_word_data(flash_word_data), .flash_busy(flash_busy),
        .app_read_enable(app_read_enable));
    flash_array_model flash_u (.clk_sys(clk_sys), .flash_start(flash_start),
        .busy_cycles(busy_cycles), .flash_busy(flash_busy));

    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) busy_d <= flash_busy;
    // Collect the word stream of a page write
    always @(negedge clk_sys) begin
        if (in_wr && busy_d) begin
            seen[flash_word_idx] = flash_word_data;
        end
    end

    function automatic logic [7:0] exp_sel(input logic [15:0] s);
        return (s == SEL_LOCK) ? lock_bits : (s == SEL_FUSE_LOW) ? fuse_low : fuse_high;
    endfunction
    task automatic chk(input logic ok, input string what);
        checks++;
        if (!ok) begin
            n_errors++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    task automatic summarize();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wr_ctrl(input logic [7:0] w);
        io_req.addr = SPC_ADDR;
        io_req.wdata = w;
        io_req.wr = 1'b1;
        tick(1);
        io_req.wr = 1'b0;
    endtask
    task automatic rd_ctrl(output logic [7:0] r);
        io_req.rd = 1'b1;
        io_req.addr = SPC_ADDR;
        tick(1);
        r = io_rdata;
        io_req.rd = 1'b0;
    endtask
    task automatic spm(input logic ld, input logic [15:0] zz, input logic [15:0] dd);
        spm_req = '{store: !ld, load: ld, z: zz, r1r0: dd};
        tick(1);
        spm_req.store = 1'b0;
        spm_req.load = 1'b0;
    endtask
    task automatic wait_idle();
        int i;
        tick(2);
        for (i = 0; i < 400; i++) begin
            if (core_stall === 1'b0 && flash_busy === 1'b0) break;
            tick(1);
        end
        if (i == 400) begin
            chk(1'b0, "idle timeout");
            summarize();
        end
    endtask

    initial begin
        void'($urandom(66));
        {lock_bits, fuse_low, fuse_high} = 24'($urandom);
        foreach (exp_buf[i]) exp_buf[i] = 16'hFFFF;
        tick(10);
        sys_rst = 1'b0;
        rd_ctrl(v);
        chk(v === SPC_RESET && app_read_enable === 1'b1, "reset values");
        // fill random words with Z0 kept zero
        repeat (20) begin
            z = {1'b0, 8'($urandom), 6'($urandom), 1'b0};
            d = 16'($urandom);
            exp_buf[z[6:1]] = d;
            wr_ctrl({3'h0, CMD_FILL});
            rd_ctrl(v);
            chk(v === 8'h01, "fill armed readback");
            spm(1'b0, z, d);
            tick(1);
            rd_ctrl(v);
            chk(v === 8'h00, "fill bit clears");
        end
        z = {1'b1, 8'($urandom), 7'h0};
        wr_ctrl({3'h0, CMD_ERASE});
        spm(1'b0, z, 16'($urandom));
        chk(flash_start === 1'b1 && flash_cmd.erase === 1'b1, "erase launch");
        chk(flash_cmd.page === z[14:7] && core_stall === 1'b1, "erase page and stall");
        wr_ctrl({3'h0, CMD_FILL});
        rd_ctrl(v);
        chk(v === {3'h0, CMD_ERASE}, "busy readback");
        wait_idle();
        rd_ctrl(v);
        chk(v === 8'h00 && app_read_enable === 1'b0, "erase done");
        wr_ctrl({3'h0, CMD_APP_READ});
        spm(1'b0, 16'h0, 16'h0);
        tick(1);
        chk(app_read_enable === 1'b1, "app read on");
        in_wr = 1'b1;
        wr_ctrl({3'h0, CMD_WRITE});
        spm(1'b0, z, 16'h1234);
        chk(flash_cmd.write === 1'b1 && flash_cmd.page === z[14:7], "write launch");
        wait_idle();
        in_wr = 1'b0;
        foreach (seen[i]) chk(seen[i] === exp_buf[i], "page word");
        foreach (codes[k]) begin
            wr_ctrl({3'h0, codes[k]});
            tick(4);
            spm(1'b0, 16'h0100, 16'h0);
            chk(flash_start === 1'b0, "late store");
            rd_ctrl(v);
            chk(v === 8'h00, "late bit clears");
        end
        repeat (8) begin
            c = 5'($urandom);
            if (c inside {CMD_FILL, CMD_ERASE, CMD_WRITE, CMD_LOCK, CMD_APP_READ}) c = 5'h07;
            wr_ctrl({3'h0, c});
            rd_ctrl(v);
            spm(1'b0, 16'h0100, 16'h0);
            chk(v === 8'h00 && flash_start === 1'b0, "odd code ignored");
        end
        busy_cycles = 16'h0002;
        d = 16'($urandom);
        wr_ctrl({3'h0, CMD_LOCK});
        tick(3);
        spm(1'b0, 16'($urandom), d);
        chk(flash_start === 1'b1 && flash_cmd.lock === 1'b1 && flash_cmd.lock_data === d[5:2], "lock set");
        wait_idle();
        foreach (sels[k]) begin
            wr_ctrl({3'h0, CMD_LOCK});
            tick(4);
            spm(1'b1, sels[k], 16'h0);
            chk(load_valid === 1'b1 && load_data === exp_sel(sels[k]), "lock fuse read");
        end
        rd_ctrl(v);
        chk(v === 8'h00, "lock bit clears");
        wr_ctrl({3'h0, CMD_LOCK});
        eeprom_write_busy = 1'b1;
        spm(1'b1, SEL_LOCK, 16'h0);
        chk(load_valid === 1'b0, "read blocked");
        tick(6);
        wr_ctrl({3'h0, CMD_WRITE});
        spm(1'b0, 16'h0080, 16'h0);
        chk(flash_start === 1'b0 && core_stall === 1'b0, "write blocked");
        // software waits for the eeprom before arming
        eeprom_write_busy = 1'b0;
        busy_cycles = 16'h50;
        wr_ctrl({3'h0, CMD_WRITE});
        spm(1'b0, 16'h0080, 16'h0);
        sys_rst = 1'b1;
        tick(2);
        chk(core_stall === 1'b1, "stall kept in reset");
        sys_rst = 1'b0;
        wait_idle();
        summarize();
    end
endmodule
`default_nettype wire
